// >>> mod_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Counts input ticks and pulses once every (modulus + 1) ticks.
module mod_divider #(
  parameter int unsigned W = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Count control
  input wire logic tick,
  input wire logic clear,
  input wire logic [W-1:0] modulus,
  // Divided output
  output logic pulse
);

  typedef struct packed {
    logic [W-1:0] count;
    logic pulse;
  } div_s;

  div_s q;
  div_s d;

  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (clear) begin
      d.count = '0;
    end else if (tick) begin
      // Compare with >= so a modulus lowered mid-count still wraps at once
      if (q.count >= modulus) begin
        d.count = '0;
        d.pulse = 1'b1;
      end else begin
        d.count = W'(q.count + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse = q.pulse;

endmodule

`default_nettype wire

// >>> osc_loop_model.sv
`timescale 1ns/1ps
`default_nettype none

module osc_loop_model #(
  parameter int unsigned HALF_INIT_NS = 400,
  parameter int unsigned STEP_NS = 20
) (
  // Comparator pin from the device
  input wire logic phase_detect_out,
  input wire logic phase_detect_oe_n,
  // Slow loop response
  input wire logic slow,
  // Oscillator feedback
  output logic tunable_oscillator
);
  int unsigned half_ns;
  int unsigned step;

  initial begin
    half_ns = HALF_INIT_NS;
    tunable_oscillator = 1'b0;
    // Odd offset keeps oscillator edges off the bus clock edges
    #7;
    forever begin
      #(half_ns);
      tunable_oscillator = ~tunable_oscillator;
      step = slow ? STEP_NS / 4 : STEP_NS;
      // A released pin leaves the filter charge, and so the rate, unchanged
      if (phase_detect_oe_n === 1'b0 && phase_detect_out === 1'b1) begin
        half_ns = (half_ns > 300 + step) ? half_ns - step : 300;
      end else if (phase_detect_oe_n === 1'b0) begin
        half_ns = (half_ns < 2000) ? half_ns + step : 2000;
      end
    end
  end
endmodule

`default_nettype wire

// >>> pixclk_pkg.sv
package pixclk_pkg;

  // APB register map; word index, byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] SYNTH_INDEX = 8'h0D;
  localparam logic [7:0] CTRL_INDEX = 8'h0E;
  localparam logic [7:0] STATUS_INDEX = 8'h10;
  localparam logic [11:0] SYNTH_ADDR = {2'b00, SYNTH_INDEX, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {2'b00, STATUS_INDEX, 2'b00};

  // Register-select code carried in the top data bits of every write
  localparam int unsigned SEL_LSB = 28;
  localparam int unsigned SEL_W = 4;
  localparam logic [3:0] SYNTH_SEL = 4'hD;
  localparam logic [3:0] CTRL_SEL = 4'hE;

  // Synthesiser divider register layout
  localparam int unsigned SYNTH_W = 16;
  localparam int unsigned MOD_W = 6;
  localparam int unsigned R_LSB = 0;
  localparam int unsigned FORCE_HI_BIT = 6;
  localparam int unsigned CLR_R_BIT = 7;
  localparam int unsigned V_LSB = 8;
  localparam int unsigned FORCE_LO_BIT = 14;
  localparam int unsigned CLR_V_BIT = 15;
  // Largest moduli after reset keep the idle synthesiser quiet
  localparam logic [15:0] SYNTH_RESET = 16'h3F3F;

  // Main control register layout
  localparam int unsigned CTRL_W = 20;
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned SRC_W = 2;
  localparam int unsigned RATE_LSB = 2;
  localparam int unsigned RATE_W = 3;
  localparam int unsigned BPP_LSB = 5;
  localparam int unsigned BPP_W = 3;
  localparam int unsigned FIFO_LSB = 8;
  localparam int unsigned FIFO_W = 3;
  localparam int unsigned INT_BIT = 12;
  localparam int unsigned DUP_BIT = 13;
  localparam int unsigned PDOWN_BIT = 14;
  localparam int unsigned TEST_LSB = 16;
  localparam int unsigned TEST_W = 4;
  // Chip comes out of reset powered down until software clears the bit
  localparam logic [19:0] CTRL_RESET = 20'h04000;

  // Status register bit positions
  localparam int unsigned ST_PIN_LEVEL = 0;
  localparam int unsigned ST_PIN_DRIVEN = 1;
  localparam int unsigned ST_NORMAL = 2;
  localparam int unsigned ST_CTRL_WRITTEN = 3;
  localparam int unsigned ST_BPP_OK = 4;
  localparam int unsigned ST_FIFO_OK = 5;
  localparam int unsigned ST_SRC_OK = 6;
  localparam int unsigned ST_PFD_LSB = 8;

  // Clock pins passing through the synchronisers
  localparam int unsigned N_CLK_IN = 4;
  localparam int unsigned IN_VIDEO = 0;
  localparam int unsigned IN_HIRES = 1;
  localparam int unsigned IN_REF = 2;
  localparam int unsigned IN_OSC = 3;

  typedef enum logic [1:0] {
    SRC_VIDEO = 2'b00,
    SRC_HIRES = 2'b01,
    SRC_REF = 2'b10,
    SRC_NONE = 2'b11
  } dot_src_e;

  typedef enum logic [2:0] {
    BPP_1 = 3'b000,
    BPP_2 = 3'b001,
    BPP_4 = 3'b010,
    BPP_8 = 3'b011,
    BPP_16 = 3'b100,
    BPP_BAD5 = 3'b101,
    BPP_32 = 3'b110,
    BPP_BAD7 = 3'b111
  } bpp_e;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP = 2'b01,
    PFD_DOWN = 2'b10
  } pfd_e;

endpackage

// >>> pixel_clock_synth_control.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_clock_synth_control (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock pins
  input wire logic video_clock_input,
  input wire logic hires_clock_input,
  input wire logic ref_clock_input,
  input wire logic tunable_oscillator,
  // Phase comparator pin
  output logic phase_detect_out,
  output logic phase_detect_oe_n,
  // Dot clock and display configuration
  output logic dot_clock_tick,
  output logic [5:0] bits_per_pixel,
  output logic bpp_supported,
  output logic [4:0] fifo_load_quads,
  output logic fifo_load_supported,
  output logic interlace_en,
  output logic dual_panel_en,
  output logic power_down,
  output logic normal_op
);

  typedef struct packed {
    logic [pixclk_pkg::SYNTH_W-1:0] synth;
    logic [pixclk_pkg::CTRL_W-1:0] ctrl;
    logic ctrl_written;
    pixclk_pkg::pfd_e pfd;
    logic pin_level;
    logic pin_oe_n;
    logic [31:0] rdata;
    logic slverr;
    logic [5:0] bpp;
    logic bpp_ok;
    logic [4:0] quads;
    logic quads_ok;
    logic interlace;
    logic dual;
    logic pdown;
    logic normal;
  } state_s;

  localparam state_s RESET_STATE = '{
    synth: pixclk_pkg::SYNTH_RESET,
    ctrl: pixclk_pkg::CTRL_RESET,
    ctrl_written: 1'b0,
    pfd: pixclk_pkg::PFD_IDLE,
    pin_level: 1'b0,
    pin_oe_n: 1'b1,
    rdata: 32'h0000_0000,
    slverr: 1'b0,
    bpp: 6'h01,
    bpp_ok: 1'b1,
    quads: 5'h00,
    quads_ok: 1'b0,
    interlace: 1'b0,
    dual: 1'b0,
    pdown: 1'b1,
    normal: 1'b0
  };

  state_s state_q;
  state_s state_d;

  // Synchronised clock-pin edges
  logic [pixclk_pkg::N_CLK_IN-1:0] pin_vec;
  logic [pixclk_pkg::N_CLK_IN-1:0] pin_rise;

  // Divider pulses and dot-clock control
  logic ref_div_pulse;
  logic osc_div_pulse;
  logic src_tick;
  logic dot_run;

  // Register fields
  logic [pixclk_pkg::MOD_W-1:0] r_mod;
  logic [pixclk_pkg::MOD_W-1:0] v_mod;
  logic force_hi;
  logic force_lo;
  logic clr_r;
  logic clr_v;
  logic [pixclk_pkg::SRC_W-1:0] src_sel;
  logic [pixclk_pkg::RATE_W-1:0] rate_sel;
  logic [pixclk_pkg::TEST_W-1:0] test_code;

  // Bus decode
  logic setup_phase;
  logic write_hit;
  logic [31:0] status_word;

  // Address names one of the three registers
  function automatic logic addr_mapped(input logic [11:0] addr);
    return (addr == pixclk_pkg::SYNTH_ADDR) || (addr == pixclk_pkg::CTRL_ADDR) ||
           (addr == pixclk_pkg::STATUS_ADDR);
  endfunction

  // Select code in the write data matches the addressed register
  function automatic logic sel_match(input logic [11:0] addr, input logic [31:0] data);
    logic [3:0] code;
    code = data[pixclk_pkg::SEL_LSB +: pixclk_pkg::SEL_W];
    return ((addr == pixclk_pkg::SYNTH_ADDR) && (code == pixclk_pkg::SYNTH_SEL)) ||
           ((addr == pixclk_pkg::CTRL_ADDR) && (code == pixclk_pkg::CTRL_SEL));
  endfunction

  // Pixel depth in bits; zero width marks an unsupported code
  function automatic logic [5:0] bpp_width(input logic [2:0] code);
    logic [5:0] w;
    w = 6'h00;
    case (pixclk_pkg::bpp_e'(code))
      pixclk_pkg::BPP_1: w = 6'h01;
      pixclk_pkg::BPP_2: w = 6'h02;
      pixclk_pkg::BPP_4: w = 6'h04;
      pixclk_pkg::BPP_8: w = 6'h08;
      pixclk_pkg::BPP_16: w = 6'h10;
      pixclk_pkg::BPP_32: w = 6'h20;
      default: w = 6'h00;
    endcase
    return w;
  endfunction

  assign pin_vec[pixclk_pkg::IN_VIDEO] = video_clock_input;
  assign pin_vec[pixclk_pkg::IN_HIRES] = hires_clock_input;
  assign pin_vec[pixclk_pkg::IN_REF] = ref_clock_input;
  assign pin_vec[pixclk_pkg::IN_OSC] = tunable_oscillator;

  genvar gi;
  generate
    for (gi = 0; gi < pixclk_pkg::N_CLK_IN; gi++) begin : g_sync
      sync_edge u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin_in(pin_vec[gi]),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  assign r_mod = state_q.synth[pixclk_pkg::R_LSB +: pixclk_pkg::MOD_W];
  assign v_mod = state_q.synth[pixclk_pkg::V_LSB +: pixclk_pkg::MOD_W];
  assign force_hi = state_q.synth[pixclk_pkg::FORCE_HI_BIT];
  assign force_lo = state_q.synth[pixclk_pkg::FORCE_LO_BIT];
  assign clr_r = state_q.synth[pixclk_pkg::CLR_R_BIT];
  assign clr_v = state_q.synth[pixclk_pkg::CLR_V_BIT];
  assign src_sel = state_q.ctrl[pixclk_pkg::SRC_LSB +: pixclk_pkg::SRC_W];
  assign rate_sel = state_q.ctrl[pixclk_pkg::RATE_LSB +: pixclk_pkg::RATE_W];
  assign test_code = state_q.ctrl[pixclk_pkg::TEST_LSB +: pixclk_pkg::TEST_W];

  // Field value is modulus minus one, so the divider wraps after value+1 ticks
  mod_divider #(.W(pixclk_pkg::MOD_W)) u_ref_div (
    .clk(pclk),
    .rst_n(presetn),
    .tick(pin_rise[pixclk_pkg::IN_REF]),
    .clear(clr_r),
    .modulus(r_mod),
    .pulse(ref_div_pulse)
  );

  mod_divider #(.W(pixclk_pkg::MOD_W)) u_osc_div (
    .clk(pclk),
    .rst_n(presetn),
    .tick(pin_rise[pixclk_pkg::IN_OSC]),
    .clear(clr_v),
    .modulus(v_mod),
    .pulse(osc_div_pulse)
  );

  always_comb begin
    case (pixclk_pkg::dot_src_e'(src_sel))
      pixclk_pkg::SRC_VIDEO: src_tick = pin_rise[pixclk_pkg::IN_VIDEO];
      pixclk_pkg::SRC_HIRES: src_tick = pin_rise[pixclk_pkg::IN_HIRES];
      pixclk_pkg::SRC_REF: src_tick = pin_rise[pixclk_pkg::IN_REF];
      default: src_tick = 1'b0;
    endcase
  end

  // Dot clock stops while powered down or in a test mode
  assign dot_run = state_q.normal;

  mod_divider #(.W(pixclk_pkg::RATE_W)) u_prescale (
    .clk(pclk),
    .rst_n(presetn),
    .tick(src_tick),
    .clear(~dot_run),
    .modulus(rate_sel),
    .pulse(dot_clock_tick)
  );

  assign setup_phase = psel & ~penable;
  assign write_hit = psel & penable & pready & pwrite & sel_match(paddr, pwdata);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pixclk_pkg::ST_PIN_LEVEL] = state_q.pin_level;
    status_word[pixclk_pkg::ST_PIN_DRIVEN] = ~state_q.pin_oe_n;
    status_word[pixclk_pkg::ST_NORMAL] = state_q.normal;
    status_word[pixclk_pkg::ST_CTRL_WRITTEN] = state_q.ctrl_written;
    status_word[pixclk_pkg::ST_BPP_OK] = state_q.bpp_ok;
    status_word[pixclk_pkg::ST_FIFO_OK] = state_q.quads_ok;
    status_word[pixclk_pkg::ST_SRC_OK] = (src_sel != pixclk_pkg::SRC_NONE);
    status_word[pixclk_pkg::ST_PFD_LSB +: 2] = state_q.pfd;
  end

  always_comb begin
    state_d = state_q;

    // Register loads; a wrong select code leaves both registers untouched
    if (write_hit && (paddr == pixclk_pkg::SYNTH_ADDR)) begin
      state_d.synth = pwdata[pixclk_pkg::SYNTH_W-1:0];
    end
    if (write_hit && (paddr == pixclk_pkg::CTRL_ADDR)) begin
      state_d.ctrl = pwdata[pixclk_pkg::CTRL_W-1:0];
      state_d.ctrl_written = 1'b1;
    end

    // Read data and error are prepared in the setup phase for the access phase
    if (setup_phase) begin
      state_d.rdata = 32'h0000_0000;
      state_d.slverr = ~addr_mapped(paddr) | (pwrite & ~sel_match(paddr, pwdata));
      if (!pwrite) begin
        case (paddr)
          pixclk_pkg::SYNTH_ADDR: state_d.rdata = {16'h0000, state_q.synth};
          pixclk_pkg::CTRL_ADDR: state_d.rdata = {12'h000, state_q.ctrl};
          pixclk_pkg::STATUS_ADDR: state_d.rdata = status_word;
          default: state_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Decoded configuration follows the control value being loaded
    state_d.bpp = bpp_width(state_d.ctrl[pixclk_pkg::BPP_LSB +: pixclk_pkg::BPP_W]);
    state_d.bpp_ok = (state_d.bpp != 6'h00);
    state_d.quads = {state_d.ctrl[pixclk_pkg::FIFO_LSB +: pixclk_pkg::FIFO_W], 2'b00};
    state_d.quads_ok = (state_d.quads != 5'h00);
    state_d.interlace = state_d.ctrl[pixclk_pkg::INT_BIT];
    state_d.dual = state_d.ctrl[pixclk_pkg::DUP_BIT];
    state_d.pdown = state_d.ctrl[pixclk_pkg::PDOWN_BIT];
    state_d.normal = ~state_d.pdown &
                     (state_d.ctrl[pixclk_pkg::TEST_LSB +: pixclk_pkg::TEST_W] == 4'h0);

    // Phase-frequency detector; coincident divided edges cancel
    case (state_q.pfd)
      pixclk_pkg::PFD_IDLE: begin
        if (ref_div_pulse && !osc_div_pulse) begin
          state_d.pfd = pixclk_pkg::PFD_UP;
        end else if (osc_div_pulse && !ref_div_pulse) begin
          state_d.pfd = pixclk_pkg::PFD_DOWN;
        end
      end
      pixclk_pkg::PFD_UP: begin
        if (osc_div_pulse) begin
          state_d.pfd = pixclk_pkg::PFD_IDLE;
        end
      end
      pixclk_pkg::PFD_DOWN: begin
        if (ref_div_pulse) begin
          state_d.pfd = pixclk_pkg::PFD_IDLE;
        end
      end
      default: state_d.pfd = pixclk_pkg::PFD_IDLE;
    endcase

    // Pin drive; force-high wins if software sets both force bits
    if (force_hi) begin
      state_d.pin_level = 1'b1;
      state_d.pin_oe_n = 1'b0;
    end else if (force_lo) begin
      state_d.pin_level = 1'b0;
      state_d.pin_oe_n = 1'b0;
    end else if (state_q.pdown) begin
      state_d.pin_level = 1'b0;
      state_d.pin_oe_n = 1'b1;
    end else begin
      case (state_d.pfd)
        pixclk_pkg::PFD_UP: begin
          state_d.pin_level = 1'b1;
          state_d.pin_oe_n = 1'b0;
        end
        pixclk_pkg::PFD_DOWN: begin
          state_d.pin_level = 1'b0;
          state_d.pin_oe_n = 1'b0;
        end
        default: begin
          // Released pin lets the loop filter hold its voltage
          state_d.pin_level = 1'b0;
          state_d.pin_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero-wait-state slave
  assign pready = 1'b1;
  assign prdata = state_q.rdata;
  assign pslverr = state_q.slverr;
  assign phase_detect_out = state_q.pin_level;
  assign phase_detect_oe_n = state_q.pin_oe_n;
  assign bits_per_pixel = state_q.bpp;
  assign bpp_supported = state_q.bpp_ok;
  assign fifo_load_quads = state_q.quads;
  assign fifo_load_supported = state_q.quads_ok;
  assign interlace_en = state_q.interlace;
  assign dual_panel_en = state_q.dual;
  assign power_down = state_q.pdown;
  assign normal_op = state_q.normal;

endmodule

`default_nettype wire

// >>> pixel_clock_synth_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_clock_synth_control_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and configuration
  input wire logic phase_detect_out,
  input wire logic phase_detect_oe_n,
  input wire logic dot_clock_tick,
  input wire logic [5:0] bits_per_pixel,
  input wire logic bpp_supported,
  input wire logic [4:0] fifo_load_quads,
  input wire logic fifo_load_supported,
  input wire logic interlace_en,
  input wire logic dual_panel_en,
  input wire logic power_down,
  input wire logic normal_op
);
  logic wr, ctrl_wr, synth_wr, bad_sel;
  logic [31:0] wd_q;

  assign wr = psel && penable && pwrite && pready;
  assign ctrl_wr = wr && paddr == pixclk_pkg::CTRL_ADDR && pwdata[31:28] == pixclk_pkg::CTRL_SEL;
  assign synth_wr = wr && paddr == pixclk_pkg::SYNTH_ADDR && pwdata[31:28] == pixclk_pkg::SYNTH_SEL;
  assign bad_sel = wr && paddr == pixclk_pkg::CTRL_ADDR && pwdata[31:28] != pixclk_pkg::CTRL_SEL;

  // Last committed write data, so decoded outputs can be judged a cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_q <= '0;
    end else if (wr) begin
      wd_q <= pwdata;
    end
  end

  function automatic logic [5:0] depth(input logic [2:0] c);
    return (c == 3'h5 || c == 3'h7) ? 6'h00 : (c == 3'h6 ? 6'h20 : 6'h01 << c);
  endfunction

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_force_high:
  assert property (synth_wr && pwdata[6] |-> ##2 !phase_detect_oe_n && phase_detect_out)
    else $error("pin not forced high");
  chk_force_low:
  assert property (synth_wr && pwdata[14] && !pwdata[6] |-> ##2 !phase_detect_oe_n && !phase_detect_out)
    else $error("pin not forced low");
  chk_depth_decode:
  assert property (ctrl_wr |=> bits_per_pixel == depth(wd_q[7:5])
    && bpp_supported == (depth(wd_q[7:5]) != 6'h00))
    else $error("pixel depth decode wrong");
  chk_fifo_decode:
  assert property (ctrl_wr |=> fifo_load_quads == {wd_q[10:8], 2'b00}
    && fifo_load_supported == (wd_q[10:8] != 3'h0))
    else $error("fifo load decode wrong");
  chk_sync_mode:
  assert property (ctrl_wr |=> interlace_en == wd_q[12] && dual_panel_en == wd_q[13])
    else $error("interlace or dual panel wrong");
  chk_normal_gate:
  assert property (ctrl_wr |=> power_down == wd_q[14]
    && normal_op == (!wd_q[14] && wd_q[19:16] == 4'h0))
    else $error("normal operation flag wrong");
  chk_sel_refused:
  assert property (bad_sel |-> pslverr)
    else $error("wrong select not flagged");
  chk_sel_ignored:
  assert property (bad_sel |=> $stable(bits_per_pixel) && $stable(fifo_load_quads)
    && $stable(power_down) && $stable(normal_op))
    else $error("wrong select changed control");
  chk_tick_gated:
  assert property (!normal_op [*3] |-> !dot_clock_tick)
    else $error("dot clock while inhibited");

  cov_force: cover property (synth_wr && pwdata[6]);
  cov_tick: cover property (dot_clock_tick);
  cov_bad_sel: cover property (bad_sel);
endmodule

bind pixel_clock_synth_control pixel_clock_synth_control_assertions u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .phase_detect_out, .phase_detect_oe_n, .dot_clock_tick, .bits_per_pixel, .bpp_supported,
  .fifo_load_quads, .fifo_load_supported, .interlace_en, .dual_panel_en, .power_down,
  .normal_op
);

`default_nettype wire

// >>> pixel_clock_synth_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_clock_synth_control_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] pins = 3'h0;
  logic slow = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, tunable_oscillator, phase_detect_out, phase_detect_oe_n, err;
  logic dot_clock_tick, bpp_supported, fifo_load_supported, interlace_en, dual_panel_en;
  logic power_down, normal_op;
  logic [5:0] bits_per_pixel;
  logic [4:0] fifo_load_quads;
  logic [19:0] cur;
  logic [15:0] v;
  int n_fail = 0;
  int compares = 0;
  int ticks = 0;
  int cyc = 0;
  int seed, r;

  pixel_clock_synth_control u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .video_clock_input(pins[0]), .hires_clock_input(pins[1]), .ref_clock_input(pins[2]),
    .tunable_oscillator, .phase_detect_out, .phase_detect_oe_n, .dot_clock_tick,
    .bits_per_pixel, .bpp_supported, .fifo_load_quads, .fifo_load_supported,
    .interlace_en, .dual_panel_en, .power_down, .normal_op
  );
  osc_loop_model u_osc (.phase_detect_out, .phase_detect_oe_n, .slow, .tunable_oscillator);

  task automatic complete_run();
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (dot_clock_tick === 1'b1) begin
      ticks <= ticks + 1;
    end
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One idle edge first, so a new request never lands in the release step
  // Waits on pready with no limit of its own; the cycle ceiling ends a hang
  task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [5:0] exp_bpp(input logic [2:0] c);
    return (c == 3'h5 || c == 3'h7) ? 6'h00 : (c == 3'h6 ? 6'h20 : 6'h01 << c);
  endfunction

  task automatic check_outs();
    @(negedge pclk);
    check("bpp", bits_per_pixel, exp_bpp(cur[7:5]));
    check("bpp_ok", bpp_supported, exp_bpp(cur[7:5]) != 6'h00);
    check("fifo", fifo_load_quads, {cur[10:8], 2'b00});
    check("fifo_ok", fifo_load_supported, cur[10:8] != 3'h0);
    check("intl", interlace_en, cur[12]);
    check("dual", dual_panel_en, cur[13]);
    check("pdown", power_down, cur[14]);
    check("normal", normal_op, !cur[14] && cur[19:16] == 4'h0);
  endtask

  task automatic put_ctrl(input logic [19:0] c, input logic ok);
    xfer(pixclk_pkg::CTRL_ADDR, 1'b1, {ok ? pixclk_pkg::CTRL_SEL : pixclk_pkg::SYNTH_SEL, 8'h00, c});
    check("ctrl err", err, !ok);
    if (ok) begin
      cur = c;
    end
    check_outs();
  endtask

  task automatic put_synth(input logic [15:0] s);
    xfer(pixclk_pkg::SYNTH_ADDR, 1'b1, {pixclk_pkg::SYNTH_SEL, 12'h000, s});
    repeat (3) @(posedge pclk);
  endtask

  task automatic check_pin(input logic oe_n, input logic lvl);
    @(negedge pclk);
    check("pin oe_n", phase_detect_oe_n, oe_n);
    if (!oe_n) begin
      check("pin level", phase_detect_out, lvl);
    end
  endtask

  // Pin high and low three cycles each, well inside what the synchroniser sees
  task automatic pulses(input int p, input int n);
    repeat (n) begin
      @(posedge pclk);
      pins[p] <= 1'b1;
      repeat (3) @(posedge pclk);
      pins[p] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask

  task automatic tick_run(input int p, input int n, input int exp);
    int t0;
    t0 = ticks;
    pulses(p, n);
    check("ticks", ticks - t0, exp);
  endtask

  initial begin
    seed = 32'h893F;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    cur = pixclk_pkg::CTRL_RESET;
    check_outs();
    put_ctrl(20'h00000, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      put_ctrl({4'h0, 2'b00, v[13:12], 1'b0, i[2:0], ~i[2:0], v[4:0]}, 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      put_ctrl({4'(1 << k), 16'h0100}, 1'b1);
    end
    tick_run(0, 4, 0);
    put_ctrl(20'h04100, 1'b1);
    put_ctrl(20'h0F0FF, 1'b0);
    xfer(12'h03C, 1'b1, 32'hE00F0FF0);
    check("unmapped err", err, 1'b1);
    check_outs();
    for (int s = 0; s < 3; s++) begin
      r = (s == 0) ? 0 : (s == 1) ? 7 : ($random(seed) & 7);
      put_ctrl({15'h0008, 3'(r), 2'(s)}, 1'b1);
      tick_run(s, (r + 1) * 2, 2);
      tick_run((s + 1) % 3, 5, 0);
    end
    put_ctrl(20'h00103, 1'b1);
    tick_run(0, 3, 0);
    put_synth(16'h0040);
    check_pin(1'b0, 1'b1);
    put_synth(16'h4000);
    check_pin(1'b0, 1'b0);
    slow <= 1'b1;
    put_synth(16'h0380);
    repeat (600) @(posedge pclk);
    check_pin(1'b0, 1'b0);
    r = 2 + ($random(seed) & 3);
    put_synth({8'h83, 2'b00, 6'(r)});
    pulses(2, r);
    check_pin(1'b0, 1'b0);
    pulses(2, 1);
    check_pin(1'b1, 1'b0);
    pulses(2, r + 1);
    check_pin(1'b0, 1'b1);
    // Detector up and driving, source code 11, depth and fifo codes supported
    xfer(pixclk_pkg::STATUS_ADDR, 1'b0, 32'h0);
    check("status rd", rd, 32'h0000_013F);
    check("status err", err, 1'b0);
    xfer(pixclk_pkg::CTRL_ADDR, 1'b0, 32'h0);
    check("ctrl rd", rd, {12'h000, cur});
    put_synth(16'h3F3F);
    xfer(pixclk_pkg::SYNTH_ADDR, 1'b0, 32'h0);
    check("synth rd", rd[15:0], 16'h3F3F);
    complete_run();
  end
endmodule

`default_nettype wire

// >>> sync_edge.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser with a rising-edge pulse; the pin must toggle
// slower than half of pclk or edges are lost.
module sync_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pin and its edge
  input wire logic pin_in,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = q.s2 & ~q.s3;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.rise;

endmodule

`default_nettype wire
